//--- shared/i2c_tba_pkg.sv
package i2c_tba_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_OWN = 4;   // Own addresses held at once
  localparam int ADDR_W  = 10;  // Own address width
  localparam int IDX_W   = 2;   // Index of an own address
  localparam int BYTE_W  = 8;   // Bits in a bus byte
  localparam int CNT_W   = 4;   // Bit counter width
  localparam int EV_W    = 2;   // Event kind width

  // ==========================================================================
  // Bus encodings and counts
  // ==========================================================================
  localparam logic [CNT_W-1:0] BYTE_BITS      = 4'h8;   // Bits before acknowledge
  localparam logic [4:0]       TEN_BIT_PREFIX = 5'h1e;  // First byte prefix 11110
  localparam logic             DIR_WRITE      = 1'b0;   // Direction bit for write
  localparam logic             LINE_HIGH      = 1'b1;   // Idle level of bus lines
  localparam logic             ACK_LEVEL      = 1'b0;   // Level driven to acknowledge

  // ==========================================================================
  // Events passed from link to system domain
  // ==========================================================================
  localparam logic [EV_W-1:0] EV_MATCH   = 2'h0;  // Full address matched
  localparam logic [EV_W-1:0] EV_DATA    = 2'h1;  // Data byte taken
  localparam logic [EV_W-1:0] EV_RELEASE = 2'h2;  // Start or stop ended selection

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef logic [NUM_OWN-1:0][ADDR_W-1:0] ownAddr_t;  // All own addresses
  typedef logic [NUM_OWN-1:0]             ownEn_t;    // Per address enable

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // Bus free or not yet started
    ST_ADDR1  = 3'b001,  // Shifting first address byte
    ST_ACK1   = 3'b010,  // Acknowledging first byte
    ST_ADDR2  = 3'b011,  // Shifting second address byte
    ST_ACK2   = 3'b100,  // Acknowledging full address
    ST_DATA   = 3'b101,  // Shifting a data byte
    ST_ACKD   = 3'b110,  // Acknowledging a data byte
    ST_IGNORE = 3'b111   // Not selected, silent until start or stop
  } linkState_e;

  typedef struct packed {
    linkState_e         st;       // Protocol state
    logic [CNT_W-1:0]   cnt;      // Bits shifted in this byte
    logic [BYTE_W-1:0]  shift;    // Byte being received
    logic [1:0]         upper;    // Upper address bits from first byte
    logic [IDX_W-1:0]   idx;      // Own address that matched
    logic               drive;    // Pulling data line low
    logic               sdaOut;   // Level driven when enabled
    logic               matched;  // Full address acknowledged
    logic               sclPrev;  // Clock line one cycle ago
    logic               sdaPrev;  // Data line one cycle ago
    logic               evToggle; // Flips per event
    logic [EV_W-1:0]    evKind;   // Kind of last event
    logic [BYTE_W-1:0]  evByte;   // Payload of last event
    logic               cfgAck;   // Echo of config request
    ownAddr_t           cfgAddr;  // Link copy of own addresses
    ownEn_t             cfgEn;    // Link copy of enables
  } link_s;

  typedef struct packed {
    logic               cfgReq;     // Flips when a new config is held
    ownAddr_t           cfgAddr;    // Held own addresses
    ownEn_t             cfgEn;      // Held enables
    logic               evSeen;     // Last event toggle consumed
    logic [BYTE_W-1:0]  rxData;     // Last data byte
    logic               rxValid;    // One cycle per data byte
    logic               addressed;  // Selected by full address
    logic [IDX_W-1:0]   matchIndex; // Which own address selected us
  } sys_s;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam link_s LINK_RESET = '{st: ST_IDLE, sclPrev: LINE_HIGH, sdaPrev: LINE_HIGH,
                                   sdaOut: ACK_LEVEL, default: '0};
  localparam sys_s  SYS_RESET  = '{default: '0};

endpackage

//--- logic/sync_two_flop.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser; the first stage feeds only the second
module sync_two_flop #(
  parameter int WIDTH = 1  // Bits synchronised in parallel
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output wire logic [WIDTH-1:0] q
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] stage1;  // Metastable stage
    logic [WIDTH-1:0] stage2;  // Settled stage
  } sync_s;

  sync_s sync;       // Both stages
  sync_s next_sync;  // Their next value

  // First stage feeds only the second
  always_comb begin
    next_sync.stage1 = d;
    next_sync.stage2 = sync.stage1;
  end

  // Both stages clear together
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync <= '0;
    end else begin
      sync <= next_sync;
    end
  end

  assign q = sync.stage2;

endmodule

//--- logic/i2c_multislave_ten_bit_address_match.sv
`timescale 1ns/1ps
// Function
// - Hold four own 10-bit addresses, answer each
// - First byte: 11110, two upper bits, direction
// - Second byte carries the eight low bits
// - Acknowledge first byte on any upper match with write direction
// - Second acknowledge only on one whole match
// - Take data only after full address acknowledge
module i2c_multislave_ten_bit_address_match
  import i2c_tba_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              linkClock,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output wire logic              sdaOut,
  output wire logic              sdaOe,
  input  wire ownAddr_t          ownAddress,
  input  wire ownEn_t            ownEnable,
  output wire logic [BYTE_W-1:0] rxData,
  output wire logic              rxValid,
  output wire logic              addressed,
  output wire logic [IDX_W-1:0]  matchIndex
);

  // ==========================================================================
  // State and crossings
  // ==========================================================================
  link_s       link;        // Link domain state
  link_s       next_link;   // Its next value
  sys_s        sys;         // System domain state
  sys_s        next_sys;    // Its next value
  logic [1:0]  pinSync;     // Synchronised clock and data lines, inverted
  logic        sclSync;     // Clock line, settled
  logic        sdaSync;     // Data line, settled
  logic        cfgReqSync;  // Config request in link domain
  logic        cfgAckSync;  // Config echo in system domain
  logic        evSync;      // Event toggle in system domain

  // Lines pass inverted, so a cleared synchroniser reads as an idle high bus
  sync_two_flop #(.WIDTH(2)) pinSyncer (
    .clock   (linkClock),
    .reset_n (reset_n),
    .d       (~{sclIn, sdaIn}),
    .q       (pinSync)
  );
  sync_two_flop #(.WIDTH(1)) cfgReqSyncer (
    .clock   (linkClock),
    .reset_n (reset_n),
    .d       (sys.cfgReq),
    .q       (cfgReqSync)
  );
  sync_two_flop #(.WIDTH(1)) cfgAckSyncer (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (link.cfgAck),
    .q       (cfgAckSync)
  );
  sync_two_flop #(.WIDTH(1)) evSyncer (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (link.evToggle),
    .q       (evSync)
  );

  assign sclSync = ~pinSync[1];
  assign sdaSync = ~pinSync[0];

  // ==========================================================================
  // Address decoding
  // ==========================================================================
  // Any enabled own address shares these upper bits
  function automatic logic upperHit(ownAddr_t a, ownEn_t en, logic [1:0] up);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_OWN; i++) begin
      if (en[i] && a[i][ADDR_W-1:BYTE_W] == up) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Whole address against each own address alone; never mixes two entries
  function automatic logic [IDX_W:0] fullHit(ownAddr_t a, ownEn_t en, logic [1:0] up,
                                             logic [BYTE_W-1:0] low);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = NUM_OWN - 1; i >= 0; i--) begin
      if (en[i] && a[i] == {up, low}) begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Link side conditions
  // ==========================================================================
  logic           sclRise;    // Clock line rose
  logic           sclFall;    // Clock line fell
  logic           startCond;  // Data fell with clock high
  logic           stopCond;   // Data rose with clock high
  logic           byteEnd;    // Falling edge closing eighth bit
  logic           firstOk;    // First byte is ours to acknowledge
  logic [IDX_W:0] fh;         // Hit flag and index of full match

  always_comb begin
    sclRise   = sclSync && !link.sclPrev;
    sclFall   = !sclSync && link.sclPrev;
    startCond = sclSync && link.sclPrev && link.sdaPrev && !sdaSync;
    stopCond  = sclSync && link.sclPrev && !link.sdaPrev && sdaSync;
    byteEnd   = sclFall && link.cnt == BYTE_BITS;
    // Prefix, write direction and upper bits of some own address
    firstOk   = link.shift[BYTE_W-1:3] == TEN_BIT_PREFIX && link.shift[0] == DIR_WRITE &&
                upperHit(link.cfgAddr, link.cfgEn, link.shift[2:1]);
    fh        = fullHit(link.cfgAddr, link.cfgEn, link.upper, link.shift);
  end

  // ==========================================================================
  // Link protocol engine
  // ==========================================================================
  // Start or stop override everything; bytes shift on rising clock edges
  always_comb begin
    next_link         = link;
    next_link.sclPrev = sclSync;
    next_link.sdaPrev = sdaSync;
    next_link.sdaOut  = ACK_LEVEL;
    // New config copied only once the held words are stable
    if (cfgReqSync != link.cfgAck) begin
      next_link.cfgAddr = sys.cfgAddr;
      next_link.cfgEn   = sys.cfgEn;
      next_link.cfgAck  = cfgReqSync;
    end
    if (startCond || stopCond) begin
      // Selection ends at either condition
      if (link.matched) begin
        next_link.evToggle = ~link.evToggle;
        next_link.evKind   = EV_RELEASE;
        next_link.evByte   = '0;
      end
      next_link.st      = startCond ? ST_ADDR1 : ST_IDLE;
      next_link.cnt     = '0;
      next_link.drive   = 1'b0;
      next_link.matched = 1'b0;
    end else begin
      case (link.st)
        ST_ADDR1, ST_ADDR2, ST_DATA: begin
          if (sclRise && link.cnt != BYTE_BITS) begin
            next_link.shift = {link.shift[BYTE_W-2:0], sdaSync};
            next_link.cnt   = link.cnt + 4'h1;
          end else if (byteEnd) begin
            next_link.cnt = '0;
            if (link.st == ST_ADDR1) begin
              // Upper match with prefix and write direction earns the first acknowledge
              next_link.upper = link.shift[2:1];
              next_link.st    = firstOk ? ST_ACK1 : ST_IGNORE;
              next_link.drive = firstOk;
            end else if (link.st == ST_ADDR2) begin
              // Only a single entry matching all ten bits selects us
              next_link.st      = fh[IDX_W] ? ST_ACK2 : ST_IGNORE;
              next_link.drive   = fh[IDX_W];
              next_link.matched = fh[IDX_W];
              next_link.idx     = fh[IDX_W-1:0];
              if (fh[IDX_W]) begin
                next_link.evToggle = ~link.evToggle;
                next_link.evKind   = EV_MATCH;
                next_link.evByte   = BYTE_W'(fh[IDX_W-1:0]);
              end
            end else begin
              // Data accepted only while selected
              next_link.st       = ST_ACKD;
              next_link.drive    = 1'b1;
              next_link.evToggle = ~link.evToggle;
              next_link.evKind   = EV_DATA;
              next_link.evByte   = link.shift;
            end
          end
        end
        ST_ACK1, ST_ACK2, ST_ACKD: begin
          // Acknowledge held through the ninth clock pulse
          if (sclFall) begin
            next_link.drive = 1'b0;
            next_link.st    = (link.st == ST_ACK1) ? ST_ADDR2 : ST_DATA;
          end
        end
        ST_IGNORE, ST_IDLE: begin
          // Silent until start or stop
          next_link.drive = 1'b0;
        end
        default: begin
          next_link.st    = ST_IDLE;
          next_link.drive = 1'b0;
        end
      endcase
    end
  end

  // Link state register
  always_ff @(posedge linkClock or negedge reset_n) begin
    if (!reset_n) begin
      link <= LINK_RESET;
    end else begin
      link <= next_link;
    end
  end

  // ==========================================================================
  // System side
  // ==========================================================================
  // Event payload is stable when its toggle arrives; bytes are far apart
  always_comb begin
    next_sys         = sys;
    next_sys.rxValid = 1'b0;
    if (cfgAckSync == sys.cfgReq && (ownAddress != sys.cfgAddr || ownEnable != sys.cfgEn)) begin
      next_sys.cfgAddr = ownAddress;
      next_sys.cfgEn   = ownEnable;
      next_sys.cfgReq  = ~sys.cfgReq;
    end
    if (evSync != sys.evSeen) begin
      next_sys.evSeen = evSync;
      case (link.evKind)
        EV_MATCH: begin
          next_sys.addressed  = 1'b1;
          next_sys.matchIndex = link.evByte[IDX_W-1:0];
        end
        EV_DATA: begin
          next_sys.rxData  = link.evByte;
          next_sys.rxValid = 1'b1;
        end
        default: begin
          next_sys.addressed = 1'b0;
        end
      endcase
    end
  end

  // System state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sys <= SYS_RESET;
    end else begin
      sys <= next_sys;
    end
  end

  assign sdaOut     = link.sdaOut;
  assign sdaOe      = link.drive;
  assign rxData     = sys.rxData;
  assign rxValid    = sys.rxValid;
  assign addressed  = sys.addressed;
  assign matchIndex = sys.matchIndex;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_addr1_end;
    link.st == ST_ADDR1 && byteEnd;
  endsequence
  sequence s_addr2_end;
    link.st == ST_ADDR2 && byteEnd;
  endsequence
  a_first_ack: assert property (@(posedge linkClock) disable iff (!reset_n)
    s_addr1_end and firstOk |=> link.st == ST_ACK1 && link.drive)
    else $error("first byte not acknowledged");
  a_first_reject: assert property (@(posedge linkClock) disable iff (!reset_n)
    s_addr1_end and (link.shift[BYTE_W-1:3] != TEN_BIT_PREFIX) |=> link.st == ST_IGNORE && !link.drive)
    else $error("bad prefix acknowledged");
  a_full_ack: assert property (@(posedge linkClock) disable iff (!reset_n)
    s_addr2_end and fh[IDX_W] |=> link.drive && link.cfgAddr[link.idx] == {link.upper, $past(link.shift)})
    else $error("full match not acknowledged on the same entry");
  a_mixed_reject: assert property (@(posedge linkClock) disable iff (!reset_n)
    s_addr2_end and !fh[IDX_W] |=> !link.drive ##0 link.st == ST_IGNORE)
    else $error("mixed address acknowledged");
  a_low_byte: assert property (@(posedge linkClock) disable iff (!reset_n)
    link.st == ST_ACK2 |-> link.cfgAddr[link.idx][BYTE_W-1:0] == link.shift)
    else $error("low bits differ from selected entry");
  a_enabled_own: assert property (@(posedge linkClock) disable iff (!reset_n)
    s_addr2_end and fh[IDX_W] |=> link.cfgEn[link.idx] && link.matched)
    else $error("matched a disabled own address");
  a_data_gate: assert property (@(posedge linkClock) disable iff (!reset_n)
    (link.st == ST_DATA || link.st == ST_ACKD) |-> link.matched)
    else $error("data taken without full match");
  a_ignore_hold: assert property (@(posedge linkClock) disable iff (!reset_n)
    link.st == ST_IGNORE && !startCond && !stopCond |=> link.st == ST_IGNORE && !link.drive)
    else $error("left ignore without start or stop");
  a_ack_release: assert property (@(posedge linkClock) disable iff (!reset_n)
    link.drive && sclFall && link.st != ST_IDLE |=> !link.drive)
    else $error("acknowledge held past ninth clock");
  a_rx_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    sys.rxValid |=> !sys.rxValid)
    else $error("data strobe longer than one cycle");

endmodule

//--- verif/i2c_bus_master_model.sv
`timescale 1ns/1ps
// ============================================================================
// Bus master partner: driven clock, open-drain data, pull-up resolved by bench
// ============================================================================
module i2c_bus_master_model
  import i2c_tba_pkg::*;
(
  input  wire logic sdaWire,  // Resolved data line
  output logic      scl,      // Clock line, master only
  output logic      sdaLow    // High pulls data line low
);
  int half = 100;  // Half bit time in ns; raised for slow runs

  // Idle bus: both lines released, clock stands still
  initial begin
    scl    = LINE_HIGH;
    sdaLow = 1'b0;
  end

  // Start or repeated start: data falls while clock high
  task automatic startCond();
    sdaLow = 1'b0;
    #half;
    scl = 1'b1;
    #half;
    sdaLow = 1'b1;
    #half;
    scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then bus idles
  task automatic stopCond();
    sdaLow = 1'b1;
    #half;
    scl = 1'b1;
    #half;
    sdaLow = 1'b0;
    #half;
  endtask

  // Eight bits MSB first, then release and sample acknowledge mid-high
  task automatic sendByte(input logic [BYTE_W-1:0] b, output logic ack);
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      sdaLow = ~b[i];
      #half;
      scl = 1'b1;
      #half;
      scl = 1'b0;
    end
    sdaLow = 1'b0;
    #half;
    scl = 1'b1;
    #(half / 2);
    ack = (sdaWire == ACK_LEVEL);
    #(half / 2);
    scl = 1'b0;
  endtask

  // Two-byte address; second byte sent even if first was refused
  task automatic sendAddr(input logic [ADDR_W-1:0] a, input logic rd, output logic ack1, output logic ack2);
    startCond();
    sendByte({TEN_BIT_PREFIX, a[9:8], rd}, ack1);
    sendByte(a[7:0], ack2);
  endtask
endmodule

//--- verif/i2c_multislave_ten_bit_address_match_tb.sv
`timescale 1ns/1ps
module i2c_multislave_ten_bit_address_match_tb import i2c_tba_pkg::*;;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam ownAddr_t SAME_UP  = {10'h3ff, 10'h300, 10'h3fa, 10'h305};  // Shared upper bits
  localparam ownAddr_t MIXED_UP = {10'h000, 10'h3a5, 10'h2c3, 10'h1a5};  // Differing upper bits
  logic              clock;
  logic              reset_n;
  logic              linkClock;
  ownAddr_t          ownAddress;
  ownEn_t            ownEnable;
  wire logic         scl;
  wire logic         sdaLow;
  wire logic         sdaWire;
  wire logic         sdaOut;
  wire logic         sdaOe;
  wire logic [7:0]   rxData;
  wire logic         rxValid;
  wire logic         addressed;
  wire logic [1:0]   matchIndex;
  int                fails    = 0;
  int                compares = 0;
  int                rxCount  = 0;  // Data pulses seen
  int                oeCount  = 0;  // Cycles with data line pulled
  logic [7:0]        lastRx;

  // Wired-AND with pull-up: released line reads high
  assign sdaWire = ~sdaLow & ~(sdaOe & (sdaOut == ACK_LEVEL));

  // ==========================================================================
  // Clocks, monitors, instances
  // ==========================================================================
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Link clock offset so edges never line up with the system clock
  initial begin
    linkClock = 1'b0;
    #2.3;
    forever #3 linkClock = ~linkClock;
  end

  // Capture each data pulse mid-cycle, where it has settled
  always @(negedge clock) begin
    if (rxValid === 1'b1) begin
      rxCount++;
      lastRx = rxData;
    end
    if (sdaOe === 1'b1) oeCount++;
  end

  i2c_bus_master_model m (.sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

  i2c_multislave_ten_bit_address_match dut (
    .clock(clock), .reset_n(reset_n), .linkClock(linkClock), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .ownAddress(ownAddress), .ownEnable(ownEnable),
    .rxData(rxData), .rxValid(rxValid), .addressed(addressed), .matchIndex(matchIndex));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic checkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Config crosses to the link domain by handshake; give it time
  task automatic setCfg(input ownAddr_t a, input ownEn_t e);
    @(posedge clock);
    #1;
    ownAddress = a;
    ownEnable  = e;
    repeat (20) @(posedge clock);
    #1;
  endtask

  // Bounded wait for selection to reach the system side
  task automatic waitAddr();
    repeat (50) begin
      if (addressed !== 1'b1) begin
        @(posedge clock);
        #1;
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Every entry selected in turn, boundary values, back-to-back data
  task automatic testEachEntry();
    logic       a1, a2, ack;
    logic [7:0] d;
    int         n;
    setCfg(SAME_UP, 4'hf);
    for (int k = 0; k < NUM_OWN; k++) begin
      m.sendAddr(SAME_UP[k], DIR_WRITE, a1, a2);
      checkBit(a1, 1'b1);
      checkBit(a2, 1'b1);
      waitAddr();
      checkBit(addressed, 1'b1);
      checkByte({6'h0, matchIndex}, 8'(k));
      for (int j = 0; j < 2; j++) begin
        d = 8'(k * 8'h55) ^ (j ? 8'hff : 8'h00);
        n = rxCount;
        m.sendByte(d, ack);
        checkBit(ack, 1'b1);
        checkByte(lastRx, d);
        checkByte(8'(rxCount - n), 8'h01);
      end
      m.stopCond();
      checkBit(addressed, 1'b0);
    end
  endtask

  // Upper bits of one entry with low bits of another, slow bus
  task automatic testCrossMatch();
    logic a1, a2, ack;
    int   n, o;
    setCfg(MIXED_UP, 4'h3);
    m.half = 300;
    m.sendAddr({2'b01, 8'hc3}, DIR_WRITE, a1, a2);
    checkBit(a1, 1'b1);
    checkBit(a2, 1'b0);
    n = rxCount;
    o = oeCount;
    m.sendByte(8'h3c, ack);
    checkBit(ack, 1'b0);
    checkByte(8'(oeCount - o), 8'h00);
    checkByte(8'(rxCount - n), 8'h00);
    checkBit(addressed, 1'b0);
    // Repeated start must end the ignored state
    m.sendAddr(10'h2c3, DIR_WRITE, a1, a2);
    checkBit(a2, 1'b1);
    waitAddr();
    checkByte({6'h0, matchIndex}, 8'h01);
    m.stopCond();
    m.half = 100;
  endtask

  // Missing prefix, disabled entry, read direction, then recovery after stop
  task automatic testRefused();
    logic a1, a2;
    // A first byte without the ten-bit prefix is never ours
    m.startCond();
    m.sendByte(8'ha4, a1);
    checkBit(a1, 1'b0);
    m.stopCond();
    m.sendAddr(10'h3a5, DIR_WRITE, a1, a2);
    checkBit(a1, 1'b0);
    checkBit(a2, 1'b0);
    m.stopCond();
    m.sendAddr(10'h1a5, ~DIR_WRITE, a1, a2);
    checkBit(a1, 1'b0);
    checkBit(a2, 1'b0);
    checkBit(addressed, 1'b0);
    m.stopCond();
    m.sendAddr(10'h1a5, DIR_WRITE, a1, a2);
    checkBit(a2, 1'b1);
    waitAddr();
    checkByte({6'h0, matchIndex}, 8'h00);
    m.stopCond();
  endtask

  // ==========================================================================
  // Sequence and verdict
  // ==========================================================================
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    ownAddress = '0;
    ownEnable  = '0;
    reset_n    = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'b1;
    checkBit(sdaOe, 1'b0);
    checkBit(addressed, 1'b0);
    checkBit(rxValid, 1'b0);
    testEachEntry();
    testCrossMatch();
    testRefused();
    finish_test();
  end

  // Whole run takes about 80 us; a hang is cut off at about four times that
  initial begin
    #300us;
    fails++;
    finish_test();
  end
endmodule
